// File: rtl/spc_core.sv
// Status register, program counter and return stack unit with APB access
// Functional notes
// - Status visible at two bank addresses
// - Bank bits 6:5 select 128-byte bank
// - Watchdog flag set by power/kick/sleep, cleared timeout
// - Low-power flag set power/kick, cleared sleep
// - Program counter is 13 bits
// - Low counter byte readable and writable
// - Upper counter bits only from holding register
// - Reset clears whole program counter
// - Low write copies holding bits 4:0 up
// - Jumps take top bits from holding 4:3
// - Eight by 13-bit stack outside address space
// - Stack pointer is hidden
// - Call or interrupt pushes counter
// - Returns pop top entry into counter
// - Push and pop leave holding register
// - Stack wraps circularly
// - No overflow or underflow indication
// - Flag results override written flag bits
// - Power flags ignore software writes
//
// Decided for this implementation: the APB register port.
module spc_core #(
	parameter int STACK_DEPTH = 8 // Return stack levels
) (
	input wire logic clk, // Core clock, 25 MHz
	input wire logic rst_b, // Async reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB access phase
	input wire logic pwrite, // APB direction
	input wire logic [11:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error, unmapped address
	input wire logic step, // Sequential advance of the counter
	input wire logic jump, // Direct jump
	input wire logic call, // Subroutine jump
	input wire logic irq_vector, // Interrupt branch
	input wire logic [spc_pkg::SPC_PC_W-1:0] vector_addr, // Interrupt vector address
	input wire logic [spc_pkg::SPC_JUMP_W-1:0] jump_target, // Embedded target field
	input wire logic ret, // Subroutine, literal or interrupt exit
	input wire logic kick_op, // Watchdog kick executed
	input wire logic sleep_op, // Sleep executed
	input wire logic wdog_timeout, // Watchdog time-out event
	input wire logic flag_upd, // Instruction updates flags
	input wire logic [1:0] flag_kind, // Add, sub, rotate or logic
	input wire logic [8:0] flag_res, // Result with carry in bit 8
	input wire logic nib_carry, // Carry from low nibble
	input wire logic rot_out, // Bit shifted out by rotate
	output logic [spc_pkg::SPC_PC_W-1:0] pc, // Program counter
	output logic [7:0] cpu_status, // Status register
	output logic [1:0] bank_sel, // Selected data bank
	output logic [8:0] bank_base // Direct bank base address bits 8:0
);
	import spc_pkg::*;

	typedef struct packed {
		logic [7:0] status;
		logic [SPC_PC_W-1:0] pc;
		logic [SPC_HOLD_W-1:0] hold;
		logic [31:0] rdata;
		logic err;
	} spc_core_s;

	spc_core_s cur;
	spc_core_s next_cur;
	logic [SPC_PC_W-1:0] stack_top;
	logic do_push;
	logic apb_setup;
	logic apb_wr;
	logic apb_rd;

	initial begin
		if (STACK_DEPTH != 8) $error("Only an eight-level stack is supported");
	end

	// Address decode shared by read and write paths
	function automatic logic is_status(input logic [11:0] a);
		return (a == SPC_ADDR_STATUS_B0) || (a == SPC_ADDR_STATUS_B1);
	endfunction

	function automatic logic is_mapped(input logic [11:0] a);
		return is_status(a) || a == SPC_ADDR_PTR_LOW || a == SPC_ADDR_UPPER_HOLD
			|| a == SPC_ADDR_BANK;
	endfunction

	assign apb_setup = psel && !penable;
	assign apb_wr = psel && penable && pwrite && is_mapped(paddr);
	assign apb_rd = apb_setup && !pwrite;
	assign do_push = call || irq_vector;

	spc_ret_stack #(
		.DEPTH(STACK_DEPTH),
		.WIDTH(SPC_PC_W)
	) u_stack (
		.clk(clk),
		.rst_b(rst_b),
		.push(do_push),
		.push_data(cur.pc),
		.pop(ret),
		.top_data(stack_top)
	);

	// Next-state logic; core events other than step win over software writes in the same cycle
	always_comb begin
		next_cur = cur;
		next_cur.err = 1'b0;
		// Read data captured in setup so the access phase completes at once
		if (apb_rd) begin
			next_cur.rdata = 32'h0000_0000;
			next_cur.err = !is_mapped(paddr);
			if (is_status(paddr)) begin
				next_cur.rdata[7:0] = cur.status;
			end else if (paddr == SPC_ADDR_PTR_LOW) begin
				next_cur.rdata[7:0] = cur.pc[7:0];
			end else if (paddr == SPC_ADDR_UPPER_HOLD) begin
				next_cur.rdata[SPC_HOLD_W-1:0] = cur.hold;
			end else if (paddr == SPC_ADDR_BANK) begin
				next_cur.rdata[1:0] = bank_sel;
			end
		end else if (apb_setup) begin
			next_cur.err = !is_mapped(paddr);
		end
		// Software writes; upper counter bits never written directly
		if (apb_wr) begin
			if (is_status(paddr)) begin
				next_cur.status[SPC_BIT_IND_PAGE] = pwdata[SPC_BIT_IND_PAGE];
				next_cur.status[SPC_BIT_BANK_HI] = pwdata[SPC_BIT_BANK_HI];
				next_cur.status[SPC_BIT_BANK_LO] = pwdata[SPC_BIT_BANK_LO];
				// Power flags keep their value on software writes
				next_cur.status[SPC_BIT_ZERO] = pwdata[SPC_BIT_ZERO];
				next_cur.status[SPC_BIT_NIBBLE] = pwdata[SPC_BIT_NIBBLE];
				next_cur.status[SPC_BIT_MSB] = pwdata[SPC_BIT_MSB];
			end else if (paddr == SPC_ADDR_PTR_LOW) begin
				next_cur.pc = {cur.hold, pwdata[7:0]};
			end else if (paddr == SPC_ADDR_UPPER_HOLD) begin
				next_cur.hold = pwdata[SPC_HOLD_W-1:0];
			end
		end
		// Flag results override any written value of the same bits
		if (flag_upd) begin
			next_cur.status[SPC_BIT_ZERO] = (flag_res[7:0] == 8'h00);
			if (flag_kind == SPC_FLAG_ADD) begin
				next_cur.status[SPC_BIT_MSB] = flag_res[8];
				next_cur.status[SPC_BIT_NIBBLE] = nib_carry;
			end else if (flag_kind == SPC_FLAG_SUB) begin
				// Carry is not-borrow: the core adds the two's complement
				next_cur.status[SPC_BIT_MSB] = flag_res[8];
				next_cur.status[SPC_BIT_NIBBLE] = nib_carry;
			end else if (flag_kind == SPC_FLAG_ROT) begin
				next_cur.status[SPC_BIT_ZERO] = cur.status[SPC_BIT_ZERO];
				next_cur.status[SPC_BIT_MSB] = rot_out;
			end
		end
		// Power event flags; timeout wins over kick
		if (kick_op) begin
			next_cur.status[SPC_BIT_WDOG] = 1'b1;
			next_cur.status[SPC_BIT_LOWPWR] = 1'b1;
		end
		if (sleep_op) begin
			next_cur.status[SPC_BIT_WDOG] = 1'b1;
			next_cur.status[SPC_BIT_LOWPWR] = 1'b0;
		end
		if (wdog_timeout) begin
			next_cur.status[SPC_BIT_WDOG] = 1'b0;
		end
		// Program flow; pushes and pops never touch the holding register
		if (ret) begin
			next_cur.pc = stack_top;
		end else if (irq_vector) begin
			next_cur.pc = vector_addr;
		end else if (jump || call) begin
			next_cur.pc = {cur.hold[SPC_HOLD_W-1:SPC_HOLD_W-2], jump_target};
		end else if (step && !(apb_wr && paddr == SPC_ADDR_PTR_LOW)) begin
			next_cur.pc = cur.pc + SPC_PC_W'(1);
		end
	end

	// Reset clears counter and sets both power flags
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cur.status <= SPC_STATUS_RST;
			cur.pc <= SPC_PC_RST;
			cur.hold <= SPC_HOLD_RST;
			cur.rdata <= 32'h0000_0000;
			cur.err <= 1'b0;
		end else begin
			cur <= next_cur;
		end
	end

	// Stack pointer has no port and no address: it stays hidden
	assign pc = cur.pc;
	assign cpu_status = cur.status;
	assign bank_sel = cur.status[SPC_BIT_BANK_HI:SPC_BIT_BANK_LO];
	assign bank_base = {bank_sel, 7'h00};
	assign prdata = cur.rdata;
	assign pready = 1'b1;
	assign pslverr = psel && penable && cur.err;

	property p_ptr_low_write;
		@(posedge clk) disable iff (!rst_b)
		(apb_wr && paddr == SPC_ADDR_PTR_LOW && !ret && !jump && !call && !irq_vector)
			|=> (pc == {$past(cur.hold), $past(pwdata[7:0])});
	endproperty
	a_ptr_low_write: assert property (p_ptr_low_write) else $error("low write load wrong");

	property p_jump;
		@(posedge clk) disable iff (!rst_b)
		((jump || call) && !ret && !irq_vector)
			|=> (pc[12:11] == $past(cur.hold[4:3]) && pc[10:0] == $past(jump_target));
	endproperty
	a_jump: assert property (p_jump) else $error("jump target wrong");

	property p_call_ret;
		@(posedge clk) disable iff (!rst_b)
		(call && !ret && !irq_vector) ##1 (!call && !ret && !irq_vector)
			##1 (ret && !call && !irq_vector) |=> (pc == $past(pc, 3));
	endproperty
	a_call_ret: assert property (p_call_ret) else $error("return address wrong");

	property p_hold_kept;
		@(posedge clk) disable iff (!rst_b)
		(do_push || ret) && !apb_wr |=> $stable(cur.hold);
	endproperty
	a_hold_kept: assert property (p_hold_kept) else $error("holding register changed");

	property p_timeout;
		@(posedge clk) disable iff (!rst_b)
		wdog_timeout |=> !cpu_status[SPC_BIT_WDOG];
	endproperty
	a_timeout: assert property (p_timeout) else $error("timeout flag not cleared");

	property p_sleep;
		@(posedge clk) disable iff (!rst_b)
		sleep_op && !wdog_timeout |=> cpu_status[4:3] == 2'b10;
	endproperty
	a_sleep: assert property (p_sleep) else $error("sleep flags wrong");

	property p_pwr_wr;
		@(posedge clk) disable iff (!rst_b)
		apb_wr && is_status(paddr) && !kick_op && !sleep_op && !wdog_timeout
			|=> $stable(cpu_status[4:3]);
	endproperty
	a_pwr_wr: assert property (p_pwr_wr) else $error("power flags written");

	property p_zero;
		@(posedge clk) disable iff (!rst_b)
		flag_upd && flag_kind != SPC_FLAG_ROT
			|=> cpu_status[SPC_BIT_ZERO] == ($past(flag_res[7:0]) == 8'h00);
	endproperty
	a_zero: assert property (p_zero) else $error("zero flag wrong");

	property p_bank;
		@(posedge clk) disable iff (!rst_b)
		bank_base == 9'(bank_sel) * 9'(SPC_BANK_SIZE);
	endproperty
	a_bank: assert property (p_bank) else $error("bank base wrong");

	property p_status_rd;
		@(posedge clk) disable iff (!rst_b)
		apb_rd && is_status(paddr) |=> prdata[7:0] == $past(cpu_status);
	endproperty
	a_status_rd: assert property (p_status_rd) else $error("status read wrong");

	property p_status_wr;
		@(posedge clk) disable iff (!rst_b)
		apb_wr && is_status(paddr) |=> cpu_status[SPC_BIT_IND_PAGE:SPC_BIT_BANK_LO]
			== $past(pwdata[SPC_BIT_IND_PAGE:SPC_BIT_BANK_LO]);
	endproperty
	a_status_wr: assert property (p_status_wr) else $error("bank bits not written");

	property p_low_rd;
		@(posedge clk) disable iff (!rst_b)
		apb_rd && paddr == SPC_ADDR_PTR_LOW |=> prdata[7:0] == $past(pc[7:0]);
	endproperty
	a_low_rd: assert property (p_low_rd) else $error("low byte read wrong");

	property p_step;
		@(posedge clk) disable iff (!rst_b)
		step && !ret && !irq_vector && !jump && !call
			&& !(apb_wr && paddr == SPC_ADDR_PTR_LOW) |=> pc == $past(pc) + SPC_PC_W'(1);
	endproperty
	a_step: assert property (p_step) else $error("counter did not advance");

	property p_pc_still;
		@(posedge clk) disable iff (!rst_b)
		!step && !ret && !irq_vector && !jump && !call
			&& !(apb_wr && paddr == SPC_ADDR_PTR_LOW) |=> $stable(pc);
	endproperty
	a_pc_still: assert property (p_pc_still) else $error("counter moved on its own");

	property p_irq;
		@(posedge clk) disable iff (!rst_b)
		irq_vector && !ret |=> pc == $past(vector_addr);
	endproperty
	a_irq: assert property (p_irq) else $error("vector not taken");

	property p_ret_top;
		@(posedge clk) disable iff (!rst_b)
		ret |=> pc == $past(stack_top);
	endproperty
	a_ret_top: assert property (p_ret_top) else $error("pop did not load counter");

	property p_kick;
		@(posedge clk) disable iff (!rst_b)
		kick_op && !sleep_op && !wdog_timeout
			|=> cpu_status[SPC_BIT_WDOG:SPC_BIT_LOWPWR] == 2'b11;
	endproperty
	a_kick: assert property (p_kick) else $error("kick flags wrong");

	property p_pwr_quiet;
		@(posedge clk) disable iff (!rst_b)
		!kick_op && !sleep_op && !wdog_timeout
			|=> $stable(cpu_status[SPC_BIT_WDOG:SPC_BIT_LOWPWR]);
	endproperty
	a_pwr_quiet: assert property (p_pwr_quiet) else $error("power flags moved");

	property p_add;
		@(posedge clk) disable iff (!rst_b)
		flag_upd && flag_kind == SPC_FLAG_ADD
			|=> cpu_status[SPC_BIT_NIBBLE:SPC_BIT_MSB] == {$past(nib_carry), $past(flag_res[8])};
	endproperty
	a_add: assert property (p_add) else $error("add carries wrong");

	property p_sub;
		@(posedge clk) disable iff (!rst_b)
		flag_upd && flag_kind == SPC_FLAG_SUB
			|=> cpu_status[SPC_BIT_NIBBLE:SPC_BIT_MSB] == {$past(nib_carry), $past(flag_res[8])};
	endproperty
	a_sub: assert property (p_sub) else $error("borrow flags wrong");

	property p_rot;
		@(posedge clk) disable iff (!rst_b)
		flag_upd && flag_kind == SPC_FLAG_ROT
			|=> cpu_status[SPC_BIT_MSB] == $past(rot_out) && $stable(cpu_status[SPC_BIT_ZERO]);
	endproperty
	a_rot: assert property (p_rot) else $error("rotate flag wrong");

	property p_logic;
		@(posedge clk) disable iff (!rst_b)
		flag_upd && flag_kind == SPC_FLAG_LOGIC && !(apb_wr && is_status(paddr))
			|=> $stable(cpu_status[SPC_BIT_NIBBLE:SPC_BIT_MSB]);
	endproperty
	a_logic: assert property (p_logic) else $error("logic op touched carries");
endmodule // spc_core

// File: rtl/spc_pkg.sv
// Package with register offsets, field positions and widths for the status/counter unit
package spc_pkg;
	// APB register byte addresses (word aligned)
	localparam logic [11:0] SPC_ADDR_STATUS_B0 = 12'h00C; // Status, bank 0 window
	localparam logic [11:0] SPC_ADDR_STATUS_B1 = 12'h20C; // Status, bank 1 window
	localparam logic [11:0] SPC_ADDR_PTR_LOW = 12'h008; // Program pointer low byte
	localparam logic [11:0] SPC_ADDR_UPPER_HOLD = 12'h028; // Upper holding register
	localparam logic [11:0] SPC_ADDR_BANK = 12'h040; // Selected bank, read only
	// Printed data-space indices of the status register
	localparam logic [7:0] SPC_IDX_STATUS_B0 = 8'h03;
	localparam logic [7:0] SPC_IDX_STATUS_B1 = 8'h83;
	// Status field positions
	localparam int SPC_BIT_IND_PAGE = 7;
	localparam int SPC_BIT_BANK_HI = 6;
	localparam int SPC_BIT_BANK_LO = 5;
	localparam int SPC_BIT_WDOG = 4;
	localparam int SPC_BIT_LOWPWR = 3;
	localparam int SPC_BIT_ZERO = 2;
	localparam int SPC_BIT_NIBBLE = 1;
	localparam int SPC_BIT_MSB = 0;
	// Widths
	localparam int SPC_PC_W = 13;
	localparam int SPC_JUMP_W = 11;
	localparam int SPC_HOLD_W = 5;
	localparam int SPC_BANK_SIZE = 128;
	// Reset values
	localparam logic [7:0] SPC_STATUS_RST = 8'h18; // Both power flags set
	localparam logic [4:0] SPC_HOLD_RST = 5'h00;
	localparam logic [12:0] SPC_PC_RST = 13'h0000;
	// Flag update kinds from the execution core
	typedef enum logic [1:0] {
		SPC_FLAG_ADD,
		SPC_FLAG_SUB,
		SPC_FLAG_ROT,
		SPC_FLAG_LOGIC
	} spc_flag_e;
endpackage : spc_pkg

// File: rtl/spc_ret_stack.sv
// Circular hardware return stack with a hidden pointer
module spc_ret_stack #(
	parameter int DEPTH = 8, // Number of entries
	parameter int WIDTH = 13 // Entry width
) (
	input wire logic clk, // Core clock
	input wire logic rst_b, // Async reset, active low
	input wire logic push, // Store push_data on top
	input wire logic [WIDTH-1:0] push_data, // Address to save
	input wire logic pop, // Remove top entry
	output logic [WIDTH-1:0] top_data // Current top entry
);
	localparam int PW = $clog2(DEPTH);

	typedef struct packed {
		logic [PW-1:0] ptr;
	} spc_stk_s;

	spc_stk_s cur;
	spc_stk_s next_cur;
	logic [WIDTH-1:0] mem [DEPTH];

	initial begin
		if (DEPTH < 2 || (1 << PW) != DEPTH) $error("DEPTH must be a power of two");
	end

	// Pointer wraps silently in both directions, no overflow flag exists
	always_comb begin
		next_cur = cur;
		if (push && !pop) begin
			next_cur.ptr = cur.ptr + PW'(1);
		end else if (pop && !push) begin
			next_cur.ptr = cur.ptr - PW'(1);
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cur <= '0;
		end else begin
			cur <= next_cur;
		end
	end

	// Storage needs no reset; a ninth push overwrites the oldest slot
	always_ff @(posedge clk) begin
		if (push) begin
			mem[push && pop ? cur.ptr - PW'(1) : cur.ptr] <= push_data;
		end
	end

	assign top_data = mem[cur.ptr - PW'(1)];

	property p_wrap;
		@(posedge clk) disable iff (!rst_b)
		(push && !pop) |=> (cur.ptr == $past(cur.ptr) + PW'(1));
	endproperty
	a_wrap: assert property (p_wrap) else $error("stack pointer did not advance");
endmodule // spc_ret_stack

// File: tb/spc_core_partner.sv
// Model of the decoder side: issues one-cycle core events to the unit
module spc_core_partner (
	input wire logic clk, // Core clock
	output logic step, // Advance counter
	output logic jump, // Direct jump
	output logic call, // Subroutine jump
	output logic irq_vector, // Interrupt branch
	output logic [12:0] vector_addr, // Vector address
	output logic [10:0] jump_target, // Embedded target
	output logic ret, // Any exit
	output logic kick_op, // Watchdog kick
	output logic sleep_op, // Sleep
	output logic wdog_timeout, // Watchdog time-out
	output logic flag_upd, // Flag update
	output logic [1:0] flag_kind, // Flag kind
	output logic [8:0] flag_res, // Result and carry
	output logic nib_carry, // Nibble carry
	output logic rot_out // Rotated-out bit
);
	timeunit 1ns;
	timeprecision 1ps;
	// Idle values; address fields hold junk outside events so stale values are never trusted
	initial begin
		{step, jump, call, irq_vector, ret, kick_op, sleep_op, wdog_timeout, flag_upd} = '0;
		{flag_kind, flag_res, nib_carry, rot_out} = '0;
		vector_addr = 13'h1555;
		jump_target = 11'h2AA;
	end
	// One event per call: 0 jump, 1 call, 2 irq, 3 exit, 4 kick, 5 sleep, 6 timeout, 7 step,
	// 8 to 11 flag update of kind 0 to 3
	task automatic fire(input int k, input logic [12:0] a);
		@(posedge clk);
		vector_addr <= a;
		jump_target <= a[10:0];
		flag_res <= a[8:0];
		nib_carry <= a[9];
		rot_out <= a[10];
		flag_kind <= 2'(k - 8);
		case (k)
			0: jump <= 1'b1;
			1: call <= 1'b1;
			2: irq_vector <= 1'b1;
			3: ret <= 1'b1;
			4: kick_op <= 1'b1;
			5: sleep_op <= 1'b1;
			6: wdog_timeout <= 1'b1;
			7: step <= 1'b1;
			default: flag_upd <= 1'b1;
		endcase
		@(posedge clk);
		{step, jump, call, irq_vector, ret, kick_op, sleep_op, wdog_timeout, flag_upd} <= '0;
		vector_addr <= ~a;
		jump_target <= ~a[10:0];
		flag_res <= ~a[8:0];
	endtask
endmodule // spc_core_partner

// File: tb/status_pc_stack_unit_bench.sv
// Self-checking testbench for the status, counter and return stack unit
module status_pc_stack_unit_bench import spc_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst_b, psel, penable, pwrite, pready, pslverr;
	logic step, jump, call, irq_vector, ret, kick_op, sleep_op, wdog_timeout, flag_upd;
	logic nib_carry, rot_out;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [1:0] flag_kind, bank_sel;
	logic [8:0] flag_res, bank_base;
	logic [12:0] vector_addr, pc, exp_pc, a;
	logic [10:0] jump_target;
	logic [7:0] cpu_status, exp_st, lo;
	logic [4:0] hold;
	logic [12:0] saved [10];
	logic [32:0] rd_q [$];
	int errors = 0;
	int num_checks = 0;

	spc_core #(.STACK_DEPTH(8)) dut (.clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .step, .jump, .call, .irq_vector, .vector_addr,
		.jump_target, .ret, .kick_op, .sleep_op, .wdog_timeout, .flag_upd, .flag_kind,
		.flag_res, .nib_carry, .rot_out, .pc, .cpu_status, .bank_sel, .bank_base);
	spc_core_partner core (.clk, .step, .jump, .call, .irq_vector, .vector_addr, .jump_target,
		.ret, .kick_op, .sleep_op, .wdog_timeout, .flag_upd, .flag_kind, .flag_res, .nib_carry,
		.rot_out);

	// 25 MHz clock
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task automatic report_and_stop();
		if (errors == 0 && num_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [32:0] got, input logic [32:0] exp);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// APB master; the wait on ready is bounded so a dead slave ends the run
	task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			errors++;
			$display("BAD %0t no ready from slave", $time);
			report_and_stop();
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd(input logic [11:0] ad, input logic [31:0] e);
		rd_q.push_back({1'b0, e});
		apb(1'b0, ad, 32'h0);
	endtask

	task automatic op(input int k, input logic [12:0] v);
		core.fire(k, v);
		#1;
	endtask

	// Scoreboard: each completed read takes the oldest note off the queue
	always @(posedge clk) begin
		if (psel && penable && pready && !pwrite) begin
			if (rd_q.size() == 0) begin
				errors++;
				$display("BAD %0t read with no expectation", $time);
			end else begin
				chk({pslverr, prdata}, rd_q.pop_front());
			end
		end
	end

	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		rst_b = 1'b0;
		void'($urandom(44));
		repeat (6) @(posedge clk);
		rst_b <= 1'b1;
		rd(SPC_ADDR_STATUS_B0, 32'h18);
		chk(32'(pc), 32'h0);
		// Software keeps the two reserved top bits clear, so only banks 0 and 1 are used
		for (int c = 1; c >= 0; c--) begin
			apb(1'b1, SPC_ADDR_STATUS_B1, {24'h0, 2'b00, c[0], 5'h07});
			exp_st = {2'b00, c[0], 5'h1F};
			rd(SPC_ADDR_STATUS_B0, {24'h0, exp_st});
			rd(SPC_ADDR_BANK, 32'(c));
			chk(32'(bank_sel), 32'(c));
			chk(32'(bank_base), c * 128);
		end
		op(5, 13'h0);
		exp_st[4:3] = 2'b10;
		chk(32'(cpu_status), 32'(exp_st));
		op(6, 13'h0);
		exp_st[4] = 1'b0;
		chk(32'(cpu_status), 32'(exp_st));
		op(4, 13'h0);
		exp_st[4:3] = 2'b11;
		chk(32'(cpu_status), 32'(exp_st));
		// Logic kind clears zero only, add sets all three, rotate loads bit 0 only
		op(11, 13'h001);
		exp_st[2:0] = 3'b011;
		chk(32'(cpu_status), 32'(exp_st));
		op(8, 13'h300);
		exp_st[2:0] = 3'b111;
		chk(32'(cpu_status), 32'(exp_st));
		op(10, 13'h001);
		exp_st[2:0] = 3'b110;
		chk(32'(cpu_status), 32'(exp_st));
		op(9, 13'h2FF);
		exp_st[2:0] = 3'b010;
		chk(32'(cpu_status), 32'(exp_st));
		hold = 5'($urandom);
		lo = 8'($urandom);
		apb(1'b1, SPC_ADDR_UPPER_HOLD, {27'h0, hold});
		apb(1'b1, SPC_ADDR_PTR_LOW, {24'h0, lo});
		#1;
		exp_pc = {hold, lo};
		chk(32'(pc), 32'(exp_pc));
		rd(SPC_ADDR_PTR_LOW, {24'h0, lo});
		op(7, 13'h0);
		exp_pc = exp_pc + 13'h1;
		chk(32'(pc), 32'(exp_pc));
		a = 13'($urandom);
		op(0, a);
		exp_pc = {hold[4:3], a[10:0]};
		chk(32'(pc), 32'(exp_pc));
		// Unmapped read: zero data and an error flag in the access phase
		rd_q.push_back({1'b1, 32'h0});
		apb(1'b0, 12'h100, 32'h0);
		// Ten pushes overrun eight levels; nine pops then wrap silently
		for (int k = 0; k < 10; k++) begin
			saved[k] = exp_pc;
			a = 13'($urandom);
			op(k == 4 ? 2 : 1, a);
			exp_pc = (k == 4) ? a : {hold[4:3], a[10:0]};
			chk(32'(pc), 32'(exp_pc));
		end
		for (int k = 0; k < 9; k++) begin
			op(3, 13'($urandom));
			chk(32'(pc), 32'(saved[k < 8 ? 9 - k : 9]));
		end
		rd(SPC_ADDR_UPPER_HOLD, {27'h0, hold});
		// Second reset in mid-run: counter clears, both power flags return
		rst_b <= 1'b0;
		@(posedge clk);
		#1;
		chk(32'(pc), 32'h0);
		chk(32'(cpu_status), 32'h18);
		@(posedge clk);
		rst_b <= 1'b1;
		op(7, 13'h0);
		chk(32'(pc), 32'h1);
		report_and_stop();
	end
endmodule // status_pc_stack_unit_bench
